// ==== hw/dma_channel_flow_and_arbiter.sv ====
// channel state machines, fifo readiness, arbiter, error and interrupt logic of the dma
//
// The register addresses and the Wishbone interface to the registers were decided locally.
`timescale 1ns/100ps
`default_nettype none
module dma_channel_flow_and_arbiter
  import dma_chan_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [PERIPH_COUNT-1:0] periph_req,
  input wire logic [PERIPH_COUNT-1:0] periph_single,
  output logic [PERIPH_COUNT-1:0] periph_ack,
  output logic [PERIPH_COUNT-1:0] periph_last,
  output mst_t mst,
  input wire logic mst_beat,
  input wire logic mst_err,
  output logic [EV_COUNT-1:0] int_out
);

  // byte-lane merge of a bus write
  function automatic logic [31:0] apply_sel(input logic [31:0] old, input logic [31:0] din,
                                            input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = din[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // beats in one transaction: cap, items left and fifo items available
  function automatic logic [3:0] beats_for(input logic [3:0] cap, input logic [LEFT_W-1:0] left,
                                           input logic [LVL_W-1:0] avail);
    logic [3:0] n;
    n = (cap == 4'h0) ? 4'h1 : cap;
    if (left < LEFT_W'(n)) begin
      n = left[3:0];
    end
    if (avail < LVL_W'(n)) begin
      n = avail[3:0];
    end
    return n;
  endfunction

  // item width code to bytes
  function automatic logic [LVL_W-1:0] wbytes(input logic [1:0] w);
    return LVL_W'(1) << w;
  endfunction

  // bus side
  logic wr; // write taken at this edge
  logic [CH_W-1:0] bus_ch; // addressed channel
  logic bus_in_ch; // address falls in a channel window
  logic [31:0] rd_val; // read mux result
  // channel state
  cfg_t cfg [CHANNELS]; // channel_configuration
  logic [SIZE_W-1:0] size [CHANNELS]; // block size in source items
  side_state_t src_st [CHANNELS];
  side_state_t dst_st [CHANNELS];
  logic [LVL_W-1:0] level [CHANNELS]; // fifo bytes held
  logic [LEFT_W-1:0] src_left [CHANNELS]; // source bytes still to fetch
  logic [LEFT_W-1:0] dst_left [CHANNELS]; // destination bytes still to deliver
  logic [3:0] src_beats [CHANNELS]; // beats left in source transaction
  logic [3:0] dst_beats [CHANNELS];
  logic [EV_COUNT-1:0] raw [CHANNELS];
  logic [EV_COUNT-1:0] mask [CHANNELS];
  // per-channel combinational terms
  logic [CHANNELS-1:0] start; // enable rising by software
  logic [CHANNELS-1:0] err_hit; // error on this channel's transfer
  logic [CHANNELS-1:0] src_ready, dst_ready;
  logic [CHANNELS-1:0] src_txn_req, dst_txn_req; // a transaction is asked for
  logic [CHANNELS-1:0] src_is_single, dst_is_single;
  logic [CHANNELS-1:0] src_beat, dst_beat; // a beat of this side completed
  logic [3:0] src_n [CHANNELS];
  logic [3:0] dst_n [CHANNELS];
  logic [EV_COUNT-1:0] ev [CHANNELS]; // event pulses
  // arbiter
  logic owner_valid, owner_dst;
  logic [CH_W-1:0] owner_ch;
  logic grant_valid, grant_dst;
  logic [CH_W-1:0] grant_ch;
  logic owner_last; // running beat closes the transaction
  // synchronisers
  logic [PERIPH_COUNT-1:0] req_m, req_s, sgl_m, sgl_s;

  // two-stage capture of peripheral requests
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_m <= '0;
      req_s <= '0;
      sgl_m <= '0;
      sgl_s <= '0;
    end else begin
      req_m <= periph_req;
      req_s <= req_m;
      sgl_m <= periph_single;
      sgl_s <= sgl_m;
    end
  end

  // bus decode
  assign bus_ch = wb_adr_i[6 +: CH_W];
  assign bus_in_ch = (wb_adr_i < CH_BASE_LIMIT) && (int'(wb_adr_i[7:6]) < CHANNELS);
  assign wr = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i;

  // ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
    end
  end

  // read mux, unmapped reads return zero
  always_comb begin
    rd_val = 32'h0;
    if (bus_in_ch) begin
      unique case (wb_adr_i[5:0])
        OFF_CFG: rd_val = cfg[bus_ch];
        OFF_SIZE: rd_val = 32'(size[bus_ch]);
        OFF_STAT: rd_val = {16'h0, 3'(src_st[bus_ch]), 3'(dst_st[bus_ch]), 5'h0, level[bus_ch]};
        default: rd_val = 32'h0;
      endcase
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        for (int e = 0; e < EV_COUNT; e++) begin
          if (wb_adr_i == OFF_RAW + 10'(e * 4)) rd_val[c] = raw[c][e];
          if (wb_adr_i == OFF_MASK + 10'(e * 4)) rd_val[c] = mask[c][e];
          if (wb_adr_i == OFF_STATUS + 10'(e * 4)) rd_val[c] = raw[c][e] & mask[c][e];
        end
      end
    end
  end

  // read data registered with the ack
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_dat_o <= 32'h0;
    end else if (wb_cyc_i && wb_stb_i && !wb_ack_o) begin
      wb_dat_o <= wb_we_i ? 32'h0 : rd_val;
    end
  end

  // per-channel readiness, requests and events
  always_comb begin
    for (int c = 0; c < CHANNELS; c++) begin
      logic [LVL_W-1:0] sw, dw, room;
      logic s_half, d_half;
      sw = wbytes(cfg[c].source_item_width);
      dw = wbytes(cfg[c].destination_item_width);
      room = LVL_W'(FIFO_DEPTH) - level[c];
      start[c] = wr && bus_in_ch && int'(bus_ch) == c && wb_adr_i[5:0] == OFF_CFG && wb_sel_i[0]
                 && wb_dat_i[0] && !cfg[c].enable;
      err_hit[c] = owner_valid && int'(owner_ch) == c && mst_err;
      // memory sides always ask and count as burst
      src_txn_req[c] = !cfg[c].src_periph || req_s[cfg[c].src_if] || sgl_s[cfg[c].src_if];
      dst_txn_req[c] = !cfg[c].dst_periph || req_s[cfg[c].dst_if] || sgl_s[cfg[c].dst_if];
      src_is_single[c] = cfg[c].src_periph && !req_s[cfg[c].src_if];
      dst_is_single[c] = cfg[c].dst_periph && !req_s[cfg[c].dst_if];
      // half thresholds only for bursts in mode one, not near the end
      s_half = cfg[c].fifo_readiness_mode && !src_is_single[c]
               && (src_left[c] >> cfg[c].source_item_width) >= LEFT_W'(HALF_DEPTH);
      d_half = cfg[c].fifo_readiness_mode && !dst_is_single[c] && !cfg[c].suspend
               && (dst_left[c] >> cfg[c].destination_item_width) >= LEFT_W'(HALF_DEPTH);
      src_ready[c] = (room >= sw) && (!s_half || level[c] < LVL_W'(HALF_DEPTH));
      dst_ready[c] = (level[c] >= dw) && (!d_half || level[c] >= LVL_W'(HALF_DEPTH));
      src_n[c] = src_is_single[c] ? 4'h1 :
                 beats_for(cfg[c].burst_length_cap, src_left[c] >> cfg[c].source_item_width,
                           room >> cfg[c].source_item_width);
      dst_n[c] = dst_is_single[c] ? 4'h1 :
                 beats_for(cfg[c].burst_length_cap, dst_left[c] >> cfg[c].destination_item_width,
                           level[c] >> cfg[c].destination_item_width);
      src_beat[c] = mst_beat && !mst_err && src_st[c] == st_xfer && owner_valid && !owner_dst
                    && int'(owner_ch) == c;
      dst_beat[c] = mst_beat && !mst_err && dst_st[c] == st_xfer && owner_valid && owner_dst
                    && int'(owner_ch) == c;
      ev[c] = '0;
      ev[c][EV_SRC] = src_beat[c] && src_beats[c] == 4'h1;
      ev[c][EV_DST] = dst_beat[c] && dst_beats[c] == 4'h1;
      ev[c][EV_BLOCK] = dst_beat[c] && dst_left[c] == LEFT_W'(dw);
      ev[c][EV_WHOLE] = ev[c][EV_BLOCK];
      ev[c][EV_ERR] = err_hit[c];
    end
  end

  // configuration and size registers; hardware ends the channel on completion or error
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < CHANNELS; c++) begin
        cfg[c] <= cfg_t'(CFG_RESET);
        size[c] <= '0;
      end
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        if (wr && bus_in_ch && int'(bus_ch) == c && wb_adr_i[5:0] == OFF_CFG) begin
          cfg[c] <= cfg_t'(apply_sel(cfg[c], wb_dat_i, wb_sel_i));
        end else if (err_hit[c] || ev[c][EV_WHOLE]) begin
          cfg[c].enable <= 1'b0;
        end
        if (wr && bus_in_ch && int'(bus_ch) == c && wb_adr_i[5:0] == OFF_SIZE) begin
          size[c] <= SIZE_W'(apply_sel(32'(size[c]), wb_dat_i, wb_sel_i));
        end
      end
    end
  end

  // fifo level and block counters; a start overwrites old contents
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < CHANNELS; c++) begin
        level[c] <= '0;
        src_left[c] <= '0;
        dst_left[c] <= '0;
      end
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        if (start[c]) begin
          level[c] <= '0;
          src_left[c] <= LEFT_W'(size[c]) << wb_dat_i[9:8];
          dst_left[c] <= LEFT_W'(size[c]) << wb_dat_i[9:8];
        end else if (src_beat[c]) begin
          level[c] <= level[c] + wbytes(cfg[c].source_item_width);
          src_left[c] <= src_left[c] - LEFT_W'(wbytes(cfg[c].source_item_width));
        end else if (dst_beat[c]) begin
          level[c] <= level[c] - wbytes(cfg[c].destination_item_width);
          dst_left[c] <= dst_left[c] - LEFT_W'(wbytes(cfg[c].destination_item_width));
        end
      end
    end
  end

  // source state machines, one per channel, running beside the destination ones
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < CHANNELS; c++) begin
        src_st[c] <= st_idle;
        src_beats[c] <= '0;
      end
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        if (err_hit[c] || !cfg[c].enable) begin
          src_st[c] <= st_idle;
        end else begin
          unique case (src_st[c])
            st_idle: src_st[c] <= st_wait;
            st_wait: begin
              // ask the arbiter only with a request and a ready fifo
              if (src_txn_req[c] && src_ready[c] && src_left[c] != '0 && src_n[c] != 4'h0) begin
                src_st[c] <= st_ask;
                src_beats[c] <= src_n[c];
              end
            end
            st_ask: begin
              if (grant_valid && !grant_dst && int'(grant_ch) == c) begin
                src_st[c] <= st_xfer;
              end
            end
            st_xfer: begin
              if (src_beat[c]) begin
                src_beats[c] <= src_beats[c] - 4'h1;
                if (src_beats[c] == 4'h1) begin
                  src_st[c] <= st_done;
                end
              end
            end
            st_done: begin
              // hold the acknowledge until the peripheral drops its request, the channel is disabled or an error hits
              if (!cfg[c].src_periph || !(req_s[cfg[c].src_if] || sgl_s[cfg[c].src_if])) begin
                src_st[c] <= st_wait;
              end
            end
            default: src_st[c] <= st_idle;
          endcase
        end
      end
    end
  end

  // destination state machines
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < CHANNELS; c++) begin
        dst_st[c] <= st_idle;
        dst_beats[c] <= '0;
      end
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        if (err_hit[c] || (!cfg[c].enable && dst_st[c] != st_done)) begin
          dst_st[c] <= st_idle;
        end else begin
          unique case (dst_st[c])
            st_idle: dst_st[c] <= st_wait;
            st_wait: begin
              if (dst_txn_req[c] && dst_ready[c] && dst_left[c] != '0 && dst_n[c] != 4'h0) begin
                dst_st[c] <= st_ask;
                dst_beats[c] <= dst_n[c];
              end
            end
            st_ask: begin
              if (grant_valid && grant_dst && int'(grant_ch) == c) begin
                dst_st[c] <= st_xfer;
              end
            end
            st_xfer: begin
              if (dst_beat[c]) begin
                dst_beats[c] <= dst_beats[c] - 4'h1;
                if (dst_beats[c] == 4'h1) begin
                  dst_st[c] <= st_done;
                end
              end
            end
            st_done: begin
              if (!cfg[c].dst_periph || !(req_s[cfg[c].dst_if] || sgl_s[cfg[c].dst_if])) begin
                dst_st[c] <= cfg[c].enable ? st_wait : st_idle;
              end
            end
            default: dst_st[c] <= st_idle;
          endcase
        end
      end
    end
  end

  // priority pick over both request lines of every channel, only while the bus is free
  always_comb begin
    logic [2:0] best;
    grant_valid = 1'b0;
    grant_dst = 1'b0;
    grant_ch = '0;
    best = 3'h0;
    if (!owner_valid) begin
      for (int c = 0; c < CHANNELS; c++) begin
        if (src_st[c] == st_ask && (!grant_valid || cfg[c].priority_level > best)) begin
          grant_valid = 1'b1;
          grant_dst = 1'b0;
          grant_ch = CH_W'(c);
          best = cfg[c].priority_level;
        end
        if (dst_st[c] == st_ask && (!grant_valid || cfg[c].priority_level > best)) begin
          grant_valid = 1'b1;
          grant_dst = 1'b1;
          grant_ch = CH_W'(c);
          best = cfg[c].priority_level;
        end
      end
    end
  end

  assign owner_last = owner_dst ? dst_beats[owner_ch] == 4'h1 : src_beats[owner_ch] == 4'h1;

  // bus ownership held until the running single or burst ends or errors
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      owner_valid <= 1'b0;
      owner_dst <= 1'b0;
      owner_ch <= '0;
    end else if (owner_valid) begin
      if (mst_err || (mst_beat && owner_last)) begin
        owner_valid <= 1'b0;
      end
    end else if (grant_valid) begin
      owner_valid <= 1'b1;
      owner_dst <= grant_dst;
      owner_ch <= grant_ch;
    end
  end

  // master command from the owner registers
  always_comb begin
    mst.active = owner_valid;
    mst.to_dst = owner_dst;
    mst.chan = owner_ch;
    mst.width = owner_dst ? cfg[owner_ch].destination_item_width : cfg[owner_ch].source_item_width;
    mst.last = owner_valid && owner_last;
  end

  // raw bits: set wins over clear, clear acts on raw and status together
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < CHANNELS; c++) begin
        raw[c] <= '0;
      end
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        for (int e = 0; e < EV_COUNT; e++) begin
          if (ev[c][e]) begin
            raw[c][e] <= 1'b1;
          end else if (wr && wb_adr_i == OFF_CLEAR + 10'(e * 4) && wb_dat_i[c]) begin
            raw[c][e] <= 1'b0;
          end
        end
      end
    end
  end

  // mask registers
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int c = 0; c < CHANNELS; c++) begin
        mask[c] <= '0;
      end
    end else begin
      for (int c = 0; c < CHANNELS; c++) begin
        for (int e = 0; e < EV_COUNT; e++) begin
          if (wr && wb_adr_i == OFF_MASK + 10'(e * 4)) begin
            mask[c][e] <= wb_dat_i[c];
          end
        end
      end
    end
  end

  // status is raw gated by mask, so a clear drops both in one cycle
  always_comb begin
    int_out = '0;
    for (int c = 0; c < CHANNELS; c++) begin
      int_out = int_out | (raw[c] & mask[c]);
    end
  end

  // handshake outputs only from the done state, never after an error
  always_comb begin
    periph_ack = '0;
    periph_last = '0;
    for (int c = 0; c < CHANNELS; c++) begin
      if (src_st[c] == st_done && cfg[c].src_periph) begin
        periph_ack[cfg[c].src_if] = 1'b1;
        periph_last[cfg[c].src_if] = src_left[c] == '0;
      end
      if (dst_st[c] == st_done && cfg[c].dst_periph) begin
        periph_ack[cfg[c].dst_if] = 1'b1;
        periph_last[cfg[c].dst_if] = dst_left[c] == '0;
      end
    end
  end

endmodule
`default_nettype wire

// ==== hw/dma_chan_pkg.sv ====
// constants, types and register layout of the dma channel flow and arbiter block
package dma_chan_pkg;
  localparam int CHANNELS = 2;                  // channel_count
  localparam int CH_W = 1;                      // channel index width
  localparam int FIFO_DEPTH = 16;               // channel_fifo_depth in bytes, must stay even
  localparam int HALF_DEPTH = FIFO_DEPTH / 2;   // half-level threshold
  localparam int LVL_W = 5;                     // fifo level counter width
  localparam int LEFT_W = 15;                   // bytes left in a block
  localparam int SIZE_W = 12;                   // block size field in source items
  localparam int PERIPH_COUNT = 13;             // handshake request lines
  localparam int EV_COUNT = 5;                  // interrupt event kinds
  // event index inside raw, mask, status and clear words
  localparam int EV_BLOCK = 0;
  localparam int EV_DST = 1;
  localparam int EV_ERR = 2;
  localparam int EV_SRC = 3;
  localparam int EV_WHOLE = 4;
  // register offsets (byte addresses)
  localparam logic [9:0] CH_BASE_LIMIT = 10'h100; // channel windows sit below this
  localparam logic [5:0] OFF_CFG = 6'h00;
  localparam logic [5:0] OFF_SIZE = 6'h04;
  localparam logic [5:0] OFF_STAT = 6'h08;
  localparam logic [9:0] OFF_RAW = 10'h100;
  localparam logic [9:0] OFF_MASK = 10'h120;
  localparam logic [9:0] OFF_STATUS = 10'h140;
  localparam logic [9:0] OFF_CLEAR = 10'h160;
  localparam logic [31:0] CFG_RESET = 32'h0000_0000;
  // fixed handshake numbering of the peripheral requests
  typedef enum logic [3:0] {
    periph_i2c_tx = 4'h0, periph_i2c_rx = 4'h1, periph_spi0_tx = 4'h2, periph_spi0_rx = 4'h3,
    periph_uart0_tx = 4'h4, periph_uart0_rx = 4'h5, periph_audio_tx = 4'h6, periph_audio_rx = 4'h7,
    periph_spi1_tx = 4'h8, periph_spi1_rx = 4'h9, periph_uart1_tx = 4'ha, periph_uart1_rx = 4'hb,
    periph_adc = 4'hc
  } periph_t;
  // channel_configuration word, bit 0 is enable
  typedef struct packed {
    logic [7:0] unused;
    logic [3:0] burst_length_cap;        // 0 reads as 1 beat
    logic [3:0] dst_if;                  // destination handshake number
    logic [3:0] src_if;                  // source handshake number
    logic [1:0] destination_item_width;  // 0:1 byte 1:2 bytes 2:4 bytes
    logic [1:0] source_item_width;
    logic [2:0] priority_level;          // higher value wins
    logic dst_periph;                    // destination is a handshaking peripheral
    logic src_periph;                    // source is a handshaking peripheral
    logic suspend;
    logic fifo_readiness_mode;
    logic enable;
  } cfg_t;
  // per-side state machine
  typedef enum logic [2:0] {
    st_idle = 3'b000, st_wait = 3'b001, st_ask = 3'b010, st_xfer = 3'b011, st_done = 3'b100
  } side_state_t;
  // master bus interface command
  typedef struct packed {
    logic active;          // a granted transfer is running
    logic to_dst;          // 1: write to destination, 0: read from source
    logic [CH_W-1:0] chan; // owning channel
    logic [1:0] width;     // item width code
    logic last;            // current beat ends the single or burst
  } mst_t;
endpackage

// ==== test/dma_chan_asserts.sv ====
// concurrent checks on the dma channel flow and arbiter ports
`timescale 1ns/100ps
`default_nettype none
module dma_chan_asserts
  import dma_chan_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic wb_ack_o,
  input wire logic [PERIPH_COUNT-1:0] periph_ack,
  input wire logic [PERIPH_COUNT-1:0] periph_last,
  input wire mst_t mst,
  input wire logic mst_beat,
  input wire logic mst_err,
  input wire logic [EV_COUNT-1:0] int_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic [4:0] beats; // beats taken in the running transaction
  // beat tally, cleared whenever the link is idle
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      beats <= 5'h00;
    end else if (!mst.active) begin
      beats <= 5'h00;
    end else if (mst_beat) begin
      beats <= beats + 5'h01;
    end
  end
  AST_ERR_CANCEL: assert property (mst.active && mst_err |=> !mst.active)
    else $error("transfer kept running after slave error");
  AST_HOLD_GRANT: assert property (mst.active && !mst_err && !(mst_beat && mst.last)
    |=> mst.active && $stable(mst.chan) && $stable(mst.to_dst)) else $error("owner changed mid transfer");
  AST_END_RELEASE: assert property (mst.active && mst_beat && mst.last |=> !mst.active)
    else $error("link not released after last beat");
  AST_BURST_CAP: assert property (mst.active && mst_beat |-> beats < 5'h0f)
    else $error("burst longer than the cap allows");
  AST_CLEAR_ERR: assert property (wb_ack_o && wb_we_i && wb_adr_i == OFF_CLEAR + 10'h008
    && wb_dat_i[1:0] == 2'b11 && !mst.active |=> !int_out[EV_ERR]) else $error("error event not cleared");
  AST_LAST_ACK: assert property ((periph_last & ~periph_ack) == '0)
    else $error("last handshake without acknowledge");
  AST_ERR_NO_ACK: assert property (mst.active && mst_err && periph_ack == '0 |=> periph_ack == '0)
    else $error("acknowledge raised after slave error");
  AST_SRC_EVENT: assert property ($rose(int_out[EV_SRC]) |-> ($past(mst_beat) && !$past(mst.to_dst))
    || ($past(wb_ack_o) && $past(wb_we_i))) else $error("source event without source beat");
  AST_DST_EVENT: assert property ($rose(int_out[EV_DST]) |-> ($past(mst_beat) && $past(mst.to_dst))
    || ($past(wb_ack_o) && $past(wb_we_i))) else $error("destination event without destination beat");
endmodule
bind dma_channel_flow_and_arbiter dma_chan_asserts u_dma_chan_asserts (.clk(clk), .rst_b(rst_b),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .periph_ack(periph_ack),
  .periph_last(periph_last), .mst(mst), .mst_beat(mst_beat), .mst_err(mst_err), .int_out(int_out));
`default_nettype wire

// ==== test/dma_ahb_slave_model.sv ====
// bus slave behind the master link: wait states, beats or an error answer
`timescale 1ns/100ps
`default_nettype none
module dma_ahb_slave_model
  import dma_chan_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire mst_t mst,
  input wire logic [3:0] slow,
  input wire logic fail,
  output logic mst_beat,
  output logic mst_err
);
  logic [3:0] cnt; // wait states left before the next answer
  // one answer per beat, never two in a row, so a finished burst is not overrun
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mst_beat <= 1'b0;
      mst_err <= 1'b0;
      cnt <= 4'h0;
    end else begin
      mst_beat <= 1'b0;
      mst_err <= 1'b0;
      if (mst.active && !mst_beat && !mst_err) begin
        if (cnt != 4'h0) begin
          cnt <= cnt - 4'h1;
        end else begin
          cnt <= slow;
          mst_beat <= !fail;
          mst_err <= fail;
        end
      end
    end
  end
endmodule
`default_nettype wire

// ==== test/dma_channel_flow_and_arbiter_tb.sv ====
// self-checking bench for the dma channel flow and arbiter
`timescale 1ns/100ps
`default_nettype none
module dma_channel_flow_and_arbiter_tb
  import dma_chan_pkg::*;
;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [9:0] adr = 10'h000;
  logic [31:0] wdat = 32'h0000_0000;
  logic [12:0] preq = 13'h0000;
  logic [12:0] psgl = 13'h0000;
  logic [3:0] slow = 4'h0;
  logic fail = 1'b0;
  logic [31:0] rdat, q;
  logic ack, beat, err;
  logic [12:0] pack, plast;
  logic [4:0] irq;
  mst_t mst;
  int bad_count = 0, checked = 0, sb = 0, db = 0, n, k;
  dma_channel_flow_and_arbiter u_dma_channel_flow_and_arbiter (.clk(clk), .rst_b(rst_b), .wb_cyc_i(cyc),
    .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .periph_req(preq), .periph_single(psgl), .periph_ack(pack), .periph_last(plast),
    .mst(mst), .mst_beat(beat), .mst_err(err), .int_out(irq));
  dma_ahb_slave_model u_dma_ahb_slave_model (.clk(clk), .rst_b(rst_b), .mst(mst), .slow(slow),
    .fail(fail), .mst_beat(beat), .mst_err(err));
  initial forever #20 clk = ~clk;
  // reference tally of bytes moved per direction
  always @(posedge clk) begin
    if (mst.active === 1'b1 && beat === 1'b1) begin
      if (mst.to_dst) db = db + (1 << mst.width);
      else sb = sb + (1 << mst.width);
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // classic single bus cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int t;
    t = 0;
    @(posedge clk);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    while (ack !== 1'b1 && t < 20) begin
      @(posedge clk);
      t++;
    end
    q = rdat;
    cyc <= 1'b0;
    if (t >= 20) bad_count++;
  endtask
  task automatic wait_irq(input int e);
    int t;
    t = 0;
    while (irq[e] !== 1'b1 && t < 3000) begin
      @(posedge clk);
      t++;
    end
    chk(32'(irq[e]), 32'h1);
  endtask
  // size first, then enable from a disabled state
  task automatic run(input int ch, input logic [11:0] size, input logic [31:0] c);
    sb = 0;
    db = 0;
    wb(1'b1, 10'(ch * 64 + 4), {20'h0, size});
    wb(1'b1, 10'(ch * 64), 32'h0);
    wb(1'b1, 10'(ch * 64), c);
  endtask
  task automatic clear_all();
    for (int e = 0; e < EV_COUNT; e++) wb(1'b1, OFF_CLEAR + 10'(4 * e), 32'h3);
    wb(1'b0, OFF_RAW, 32'h0);
    chk(32'(irq), 32'h0);
  endtask
  function automatic logic [31:0] cw(logic m, logic p, logic [3:0] i, logic [3:0] cap, logic [1:0] w);
    return {8'h00, cap, 4'h0, i, w, w, 3'h5, 1'b0, p, 1'b0, m, 1'b1};
  endfunction
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    wrap_up();
  end
  initial begin
    void'($urandom(32'hbd20));
    repeat (5) @(posedge clk);
    rst_b <= 1'b1;
    wb(1'b0, OFF_CFG, 32'h0);
    chk(q, CFG_RESET);
    wb(1'b0, 10'h3fc, 32'h0);
    chk(q, 32'h0);
    for (int e = 0; e < EV_COUNT; e++) wb(1'b1, OFF_MASK + 10'(4 * e), 32'h3);
    // slave error on a peripheral channel with its request pending
    k = $urandom_range(12);
    fail <= 1'b1;
    preq[k] <= 1'b1;
    run(1, 12'h004, cw(1'b0, 1'b1, 4'(k), 4'h3, 2'h0));
    wait_irq(EV_ERR);
    chk(32'(pack), 32'h0);
    wb(1'b0, 10'h040, 32'h0);
    chk(32'(q[0]), 32'h0);
    preq[k] <= 1'b0;
    fail <= 1'b0;
    clear_all();
    // memory transfers, both channels and both readiness modes
    for (int i = 0; i < 4; i++) begin
      n = $urandom_range(40, 1);
      k = $urandom_range(2);
      slow <= 4'($urandom_range(3));
      run(i % 2, 12'(n), cw(1'(i / 2), 1'b0, 4'h0, 4'($urandom_range(15)), 2'(k)) | (32'(i == 3) << 2));
      wait_irq(EV_WHOLE);
      repeat (2) @(posedge clk);
      chk(32'(irq), 32'h1b);
      chk(sb, n << k);
      chk(db, n << k);
      wb(1'b1, OFF_MASK + 10'(4 * EV_SRC), 32'h0);
      @(posedge clk);
      chk(32'(irq[EV_SRC]), 32'h0);
      wb(1'b1, OFF_MASK + 10'(4 * EV_SRC), 32'h3);
      clear_all();
    end
    // every handshake number, single request arriving late
    for (int p = 0; p < PERIPH_COUNT; p++) begin
      run(0, 12'h001, cw(1'b0, 1'b1, 4'(p), 4'h0, 2'h0));
      repeat (10) @(posedge clk);
      chk(32'(irq), 32'h0);
      psgl[p] <= 1'b1;
      wait_irq(EV_WHOLE);
      chk(32'(pack), 32'(1) << p);
      chk(32'(plast), 32'(1) << p);
      psgl[p] <= 1'b0;
      clear_all();
    end
    wrap_up();
  end
endmodule
`default_nettype wire
